// >>> drs_defines.vh
// drs_defines.vh: state codes, message codes and timing counts for the swap engine
// assumes a 10 MHz engine clock; included by the engine, the checker and the bench
`ifndef DRS_DEFINES_VH
`define DRS_DEFINES_VH

// engine states
`define DRS_ST_SNK_READY      5'h00
`define DRS_ST_SNK_ACCEPT     5'h01
`define DRS_ST_SNK_TO_OFF     5'h02
`define DRS_ST_SNK_ASSERT_RP  5'h03
`define DRS_ST_SNK_SOURCE_ON  5'h04
`define DRS_ST_SNK_SEND_SWAP  5'h05
`define DRS_ST_SNK_REJECT     5'h06
`define DRS_ST_SRC_STARTUP    5'h07
`define DRS_ST_ERROR_RECOVERY 5'h08
`define DRS_ST_SRC_READY      5'h09
`define DRS_ST_FRS_CC_SIGNAL  5'h0a
`define DRS_ST_FRS_EVALUATE   5'h0b
`define DRS_ST_FRS_ACCEPT     5'h0c
`define DRS_ST_FRS_TO_OFF     5'h0d
`define DRS_ST_FRS_ASSERT_RD  5'h0e
`define DRS_ST_FRS_WAIT_SRC   5'h0f
`define DRS_ST_SNK_STARTUP    5'h10
`define DRS_ST_SRC_HARD_RESET 5'h11
`define DRS_ST_DEFAULT        5'h12

// message type codes on the protocol layer port
`define DRS_MSG_NONE    4'h0
`define DRS_MSG_ACCEPT  4'h1
`define DRS_MSG_REJECT  4'h2
`define DRS_MSG_WAIT    4'h3
`define DRS_MSG_PS_RDY  4'h4
`define DRS_MSG_PR_SWAP 4'h5
`define DRS_MSG_FR_SWAP 4'h6

// clock in kHz, timer figures in microseconds, timer width in bits
`define DRS_CLOCK_KHZ          10000
`define DRS_SENDER_RESP_US     27000
`define DRS_SOURCE_OFF_US      750000
`define DRS_SOURCE_ON_US       435000
`define DRS_TIMER_WIDTH        24

`endif

// >>> drs_port_model.sv
// drs_port_model.sv: far port as seen through the protocol layer
// answers each transmit request, delivered or lost, after a set latency
`timescale 1ns/1ps
`default_nettype none
module drs_port_model (
  input  wire logic       clock,
  input  wire logic       tx_req,
  input  wire logic [3:0] tx_type,
  input  wire logic [3:0] lat,
  input  wire logic       fail,
  output var  logic       tx_done,
  output var  logic       tx_failed,
  output var  logic [3:0] last
);
  int cnt;
  initial
  begin
    tx_done = 1'h0;
    tx_failed = 1'h0;
    last = 4'h0;
    cnt = 0;
  end
  // answers only after a request, never unprompted
  always @(negedge clock)
  begin
    tx_done = 1'h0;
    tx_failed = 1'h0;
    if (cnt == 1)
    begin
      tx_failed = fail;
      tx_done = !fail;
    end
    if (cnt != 0)
      cnt = cnt - 1;
    if (tx_req)
    begin
      cnt = lat + 1;
      last = tx_type;
    end
  end
endmodule // drs_port_model
`default_nettype wire

// >>> drs_swap_checker.sv
// drs_swap_checker.sv: assertions on the swap engine ports
// assumes the engine clock and active-high async reset; bound below
`timescale 1ns/1ps
`default_nettype none
`include "drs_defines.vh"
module drs_swap_checker #(
  parameter SENDER_RESP_CYCLES = 20,
  parameter SOURCE_OFF_CYCLES  = 50,
  parameter SOURCE_ON_CYCLES   = 40
) (
  input wire logic       clock,
  input wire logic       rst,
  input wire logic       rx_valid,
  input wire logic [3:0] rx_type,
  input wire logic       tx_done,
  input wire logic       tx_failed,
  input wire logic       tx_req,
  input wire logic [3:0] tx_type,
  input wire logic       pm_reject_wait,
  input wire logic       pm_eval_not_ok,
  input wire logic       pm_contract,
  input wire logic       frs_cc_detect_pin,
  input wire logic       hard_reset_pin,
  input wire logic       assert_rp_req,
  input wire logic       error_recovery,
  input wire logic       src_hard_reset,
  input wire logic [4:0] state
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // cycles in the present state, zero on its entry cycle
  logic [15:0] held;
  logic [4:0]  last;
  wire  [15:0] age = (state == last) ? held : 16'h0000;
  always @(posedge clock or posedge rst)
    if (rst)
    begin
      held <= 16'h0000;
      last <= `DRS_ST_DEFAULT;
    end
    else
    begin
      held <= age + 16'h0001;
      last <= state;
    end
  accept_send_a:
    assert property ($rose(state == `DRS_ST_SNK_ACCEPT) |-> ##[1:2]
      (tx_req && tx_type == `DRS_MSG_ACCEPT)) else $error("accept not sent");
  off_timer_a:
    assert property (state == `DRS_ST_SNK_TO_OFF |-> age <= SOURCE_OFF_CYCLES + 4)
      else $error("source off wait too long");
  ps_rdy_rp_a:
    assert property (state == `DRS_ST_SNK_TO_OFF && rx_valid && rx_type == `DRS_MSG_PS_RDY
      |=> state == `DRS_ST_SNK_ASSERT_RP) else $error("ps_rdy ignored");
  rp_level_a:
    assert property (assert_rp_req == (state == `DRS_ST_SNK_ASSERT_RP))
      else $error("pull-up request wrong");
  psrdy_lost_a:
    assert property (state == `DRS_ST_SNK_SOURCE_ON && tx_failed |=>
      state == `DRS_ST_ERROR_RECOVERY && error_recovery) else $error("lost ps_rdy");
  swap_answer_a:
    assert property (state == `DRS_ST_SNK_SEND_SWAP && rx_valid && (rx_type ==
      `DRS_MSG_REJECT || rx_type == `DRS_MSG_WAIT) |=> state == `DRS_ST_SNK_READY)
      else $error("refusal not taken");
  swap_accept_a:
    assert property (state == `DRS_ST_SNK_SEND_SWAP && rx_valid && rx_type ==
      `DRS_MSG_ACCEPT |=> state == `DRS_ST_SNK_TO_OFF) else $error("accept not taken");
  resp_timer_a:
    assert property (state == `DRS_ST_SNK_SEND_SWAP |-> age <= SENDER_RESP_CYCLES + 4)
      else $error("response wait too long");
  reject_kind_a:
    assert property ($rose(state == `DRS_ST_SNK_REJECT) |-> ##[1:2] (tx_req &&
      tx_type == (pm_reject_wait ? `DRS_MSG_WAIT : `DRS_MSG_REJECT)))
      else $error("wrong refusal sent");
  reject_done_a:
    assert property (state == `DRS_ST_SNK_REJECT && tx_done |=> state == `DRS_ST_SNK_READY)
      else $error("reject state stuck");
  hard_reset_a:
    assert property ($rose(hard_reset_pin) |-> ##[1:5] state == `DRS_ST_DEFAULT)
      else $error("hard reset ignored");
  cc_signal_a:
    assert property ($rose(frs_cc_detect_pin) && pm_contract && state == `DRS_ST_SNK_READY
      |-> ##[1:5] state == `DRS_ST_FRS_CC_SIGNAL) else $error("cc signal ignored");
  eval_refuse_a:
    assert property (state == `DRS_ST_FRS_EVALUATE && $past(state) == `DRS_ST_FRS_EVALUATE
      && pm_eval_not_ok |=> src_hard_reset) else $error("refusal not handled");
  wait_timer_a:
    assert property (state == `DRS_ST_FRS_WAIT_SRC |-> age <= SOURCE_ON_CYCLES + 4)
      else $error("source on wait too long");
endmodule // drs_swap_checker
bind drs_swap_engine drs_swap_checker #(
  .SENDER_RESP_CYCLES(SENDER_RESP_CYCLES),
  .SOURCE_OFF_CYCLES(SOURCE_OFF_CYCLES),
  .SOURCE_ON_CYCLES(SOURCE_ON_CYCLES)
) u_chk (
  .clock, .rst, .rx_valid, .rx_type, .tx_done, .tx_failed, .tx_req, .tx_type,
  .pm_reject_wait, .pm_eval_not_ok, .pm_contract, .frs_cc_detect_pin,
  .hard_reset_pin, .assert_rp_req, .error_recovery, .src_hard_reset, .state
);
`default_nettype wire

// >>> drs_swap_engine.v
// drs_swap_engine.v: policy engine for power role swap (sink to source) and
// fast role swap (source to sink) of a dual-role port
// assumes protocol layer and policy manager run on the same clock; the
// fast swap cc detect and hard reset arrive asynchronously and are synchronised
`timescale 1ns/1ps
`default_nettype none
`include "drs_defines.vh"

module drs_swap_engine #(
  parameter SENDER_RESP_CYCLES = `DRS_SENDER_RESP_US * (`DRS_CLOCK_KHZ / 1000),
  parameter SOURCE_OFF_CYCLES  = `DRS_SOURCE_OFF_US * (`DRS_CLOCK_KHZ / 1000),
  parameter SOURCE_ON_CYCLES   = `DRS_SOURCE_ON_US * (`DRS_CLOCK_KHZ / 1000),
  parameter TW                 = `DRS_TIMER_WIDTH
) (
  input  wire       clock,
  input  wire       rst,
  // protocol layer
  input  wire       rx_valid,
  input  wire [3:0] rx_type,
  input  wire       tx_done,
  input  wire       tx_failed,
  output reg        tx_req,
  output reg  [3:0] tx_type,
  // policy manager requests and answers
  input  wire       pm_swap_request,
  input  wire       pm_start_sink_ready,
  input  wire       pm_start_src_ready,
  input  wire       pm_reject_wait,
  input  wire       pm_reject_request,
  input  wire       pm_eval_ok,
  input  wire       pm_eval_not_ok,
  input  wire       pm_rp_asserted,
  input  wire       pm_rd_asserted,
  input  wire       pm_source_on,
  input  wire       pm_vbus_safe5v,
  input  wire       pm_contract,
  // asynchronous pins
  input  wire       frs_cc_detect_pin,
  input  wire       hard_reset_pin,
  // outputs to policy manager
  output reg        sink_off_req,
  output reg        assert_rp_req,
  output reg        assert_rd_req,
  output reg        source_on_req,
  output reg        frs_eval_query,
  output reg        error_recovery,
  output reg        src_hard_reset,
  output reg  [4:0] state
);
  reg  [4:0] next_state;
  reg        tx_pending;
  wire [1:0] pin_sync;
  wire       frs_cc_detect;
  wire       hard_reset;
  wire       resp_expired;
  wire       off_expired;
  wire       on_expired;
  wire       enter;
  reg        entered;

  drs_sync #(.WIDTH(2)) u_sync (
    .clock    (clock),
    .rst      (rst),
    .async_in ({hard_reset_pin, frs_cc_detect_pin}),
    .sync_out (pin_sync)
  );
  assign frs_cc_detect = pin_sync[0];
  assign hard_reset    = pin_sync[1];

  // entry pulse: first cycle in a new state
  assign enter = entered;

  function rx_is;
    input       valid;
    input [3:0] got;
    input [3:0] want;
    begin
      rx_is = valid && (got == want);
    end
  endfunction

  wire leave = (next_state != state);

  drs_timer #(.WIDTH(TW)) u_resp_timer (
    .clock   (clock),
    .rst     (rst),
    .start   (enter && state == `DRS_ST_SNK_SEND_SWAP),
    .stop    (leave && state == `DRS_ST_SNK_SEND_SWAP),
    .load    (SENDER_RESP_CYCLES[TW-1:0]),
    .expired (resp_expired)
  );

  drs_timer #(.WIDTH(TW)) u_off_timer (
    .clock   (clock),
    .rst     (rst),
    .start   (enter && state == `DRS_ST_SNK_TO_OFF),
    .stop    (leave && state == `DRS_ST_SNK_TO_OFF),
    .load    (SOURCE_OFF_CYCLES[TW-1:0]),
    .expired (off_expired)
  );

  drs_timer #(.WIDTH(TW)) u_on_timer (
    .clock   (clock),
    .rst     (rst),
    .start   (enter && state == `DRS_ST_FRS_WAIT_SRC),
    .stop    (leave && state == `DRS_ST_FRS_WAIT_SRC),
    .load    (SOURCE_ON_CYCLES[TW-1:0]),
    .expired (on_expired)
  );

  // next state; hard reset overrides any state, cc fast swap detect with pm_contract any state outside the fast swap path
  always @*
  begin
    next_state = state;
    if (hard_reset)
      next_state = `DRS_ST_DEFAULT;
    else if (frs_cc_detect && pm_contract && state != `DRS_ST_FRS_CC_SIGNAL
             && state != `DRS_ST_FRS_EVALUATE && state != `DRS_ST_FRS_ACCEPT
             && state != `DRS_ST_FRS_TO_OFF && state != `DRS_ST_FRS_ASSERT_RD
             && state != `DRS_ST_FRS_WAIT_SRC)
      next_state = `DRS_ST_FRS_CC_SIGNAL;
    else
    begin
      case (state)
        `DRS_ST_DEFAULT:
          if (pm_start_sink_ready)
            next_state = `DRS_ST_SNK_READY;
          else if (pm_start_src_ready)
            next_state = `DRS_ST_SRC_READY;
        `DRS_ST_SNK_READY:
          if (rx_is(rx_valid, rx_type, `DRS_MSG_PR_SWAP))
            next_state = pm_reject_request ? `DRS_ST_SNK_REJECT : `DRS_ST_SNK_ACCEPT;
          else if (pm_swap_request)
            next_state = `DRS_ST_SNK_SEND_SWAP;
        `DRS_ST_SNK_ACCEPT:
          if (tx_done)
            next_state = `DRS_ST_SNK_TO_OFF;
        `DRS_ST_SNK_TO_OFF:
          if (off_expired)
            next_state = `DRS_ST_ERROR_RECOVERY;
          else if (rx_is(rx_valid, rx_type, `DRS_MSG_PS_RDY))
            next_state = `DRS_ST_SNK_ASSERT_RP;
        `DRS_ST_SNK_ASSERT_RP:
          if (pm_rp_asserted)
            next_state = `DRS_ST_SNK_SOURCE_ON;
        `DRS_ST_SNK_SOURCE_ON:
          if (tx_failed)
            next_state = `DRS_ST_ERROR_RECOVERY;
          else if (tx_done && tx_type == `DRS_MSG_PS_RDY)
            next_state = `DRS_ST_SRC_STARTUP;
        `DRS_ST_SNK_SEND_SWAP:
          if (rx_is(rx_valid, rx_type, `DRS_MSG_ACCEPT))
            next_state = `DRS_ST_SNK_TO_OFF;
          else if (rx_is(rx_valid, rx_type, `DRS_MSG_REJECT) ||
                   rx_is(rx_valid, rx_type, `DRS_MSG_WAIT) || resp_expired)
            next_state = `DRS_ST_SNK_READY;
        `DRS_ST_SNK_REJECT:
          if (tx_done || tx_failed)
            next_state = `DRS_ST_SNK_READY;
        `DRS_ST_SRC_READY:
          if (rx_is(rx_valid, rx_type, `DRS_MSG_FR_SWAP))
            next_state = `DRS_ST_FRS_EVALUATE;
        `DRS_ST_FRS_CC_SIGNAL:
          if (rx_is(rx_valid, rx_type, `DRS_MSG_FR_SWAP))
            next_state = `DRS_ST_FRS_EVALUATE;
        `DRS_ST_FRS_EVALUATE:
          if (!entered && (pm_eval_not_ok || !frs_cc_detect))
            next_state = `DRS_ST_SRC_HARD_RESET;
          else if (!entered && pm_eval_ok)
            next_state = `DRS_ST_FRS_ACCEPT;
        `DRS_ST_FRS_ACCEPT:
          if (tx_failed)
            next_state = `DRS_ST_SRC_HARD_RESET;
          else if (tx_done)
            next_state = `DRS_ST_FRS_TO_OFF;
        `DRS_ST_FRS_TO_OFF:
          if (pm_vbus_safe5v)
            next_state = `DRS_ST_FRS_ASSERT_RD;
        `DRS_ST_FRS_ASSERT_RD:
          if (pm_rd_asserted)
            next_state = `DRS_ST_FRS_WAIT_SRC;
        `DRS_ST_FRS_WAIT_SRC:
          if (on_expired || tx_failed)
            next_state = `DRS_ST_ERROR_RECOVERY;
          else if (rx_is(rx_valid, rx_type, `DRS_MSG_PS_RDY))
            next_state = `DRS_ST_SNK_STARTUP;
        // terminal states hand over to the wider engine, which resets us
        `DRS_ST_SRC_STARTUP, `DRS_ST_SNK_STARTUP,
        `DRS_ST_ERROR_RECOVERY, `DRS_ST_SRC_HARD_RESET:
          next_state = state;
        default:
          next_state = `DRS_ST_DEFAULT;
      endcase
    end
  end

  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state      <= `DRS_ST_DEFAULT;
      entered    <= 1'b0;
    end
    else
    begin
      state      <= next_state;
      entered    <= (next_state != state);
    end
  end

  // transmit requests: one pulse on entry to a sending state, or in source-on once pm_source_on is set
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      tx_req     <= 1'b0;
      tx_type    <= `DRS_MSG_NONE;
      tx_pending <= 1'b0;
    end
    else
    begin
      tx_req <= 1'b0;
      if (tx_done || tx_failed)
        tx_pending <= 1'b0;
      if (enter)
      begin
        case (state)
          `DRS_ST_SNK_ACCEPT, `DRS_ST_FRS_ACCEPT:
          begin
            tx_req     <= 1'b1;
            tx_type    <= `DRS_MSG_ACCEPT;
            tx_pending <= 1'b1;
          end
          `DRS_ST_SNK_SEND_SWAP:
          begin
            tx_req     <= 1'b1;
            tx_type    <= `DRS_MSG_PR_SWAP;
            tx_pending <= 1'b1;
          end
          `DRS_ST_SNK_REJECT:
          begin
            tx_req     <= 1'b1;
            // wait when the manager still evaluates, otherwise reject
            tx_type    <= pm_reject_wait ? `DRS_MSG_WAIT : `DRS_MSG_REJECT;
            tx_pending <= 1'b1;
          end
          `DRS_ST_FRS_WAIT_SRC:
          begin
            tx_req     <= 1'b1;
            tx_type    <= `DRS_MSG_PS_RDY;
            tx_pending <= 1'b1;
          end
          // no hold of tx_pending here, so a same-cycle completion still clears it
          default:
            tx_req <= 1'b0;
        endcase
      end
      // source-on leaves through PS_RDY; the engine holds until it is sent or lost
      else if (state == `DRS_ST_SNK_SOURCE_ON && pm_source_on && !tx_pending)
      begin
        tx_req     <= 1'b1;
        tx_type    <= `DRS_MSG_PS_RDY;
        tx_pending <= 1'b1;
      end
    end
  end

  // level requests to the policy manager, held while in the state
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      sink_off_req   <= 1'b0;
      assert_rp_req  <= 1'b0;
      assert_rd_req  <= 1'b0;
      source_on_req  <= 1'b0;
      frs_eval_query <= 1'b0;
      error_recovery <= 1'b0;
      src_hard_reset <= 1'b0;
    end
    else
    begin
      // timer starts on entry; sink-off request follows a cycle later
      sink_off_req   <= (state == `DRS_ST_SNK_TO_OFF);
      assert_rp_req  <= (next_state == `DRS_ST_SNK_ASSERT_RP);
      assert_rd_req  <= (next_state == `DRS_ST_FRS_ASSERT_RD);
      source_on_req  <= (next_state == `DRS_ST_SNK_SOURCE_ON) ||
                        (next_state == `DRS_ST_SRC_STARTUP);
      frs_eval_query <= (next_state == `DRS_ST_FRS_EVALUATE);
      error_recovery <= (next_state == `DRS_ST_ERROR_RECOVERY);
      src_hard_reset <= (next_state == `DRS_ST_SRC_HARD_RESET);
    end
  end
endmodule // drs_swap_engine
`default_nettype wire

// >>> drs_swap_engine_tb_top.sv
// drs_swap_engine_tb_top.sv: self-checking bench for the swap engine
// assumes drs_port_model answers transmissions; timers shortened for sim
`timescale 1ns/1ps
`default_nettype none
`include "drs_defines.vh"
module drs_swap_engine_tb_top;
  localparam RESP = 20;
  localparam OFF  = 50;
  localparam ON   = 40;
  logic       clock, rst, rx_valid, tx_done, tx_failed, tx_req, fail;
  logic [3:0] rx_type, tx_type, lat, last;
  logic       pm_swap_request, pm_start_sink_ready, pm_start_src_ready;
  logic       pm_reject_wait, pm_reject_request, pm_eval_ok, pm_eval_not_ok;
  logic       pm_rp_asserted, pm_rd_asserted, pm_source_on, pm_vbus_safe5v;
  logic       pm_contract, frs_cc_detect_pin, hard_reset_pin;
  logic       sink_off_req, assert_rp_req, assert_rd_req, source_on_req;
  logic       frs_eval_query, error_recovery, src_hard_reset;
  logic [4:0] state;
  int         mismatches, n_checks, n, k;
  drs_swap_engine #(
    .SENDER_RESP_CYCLES(RESP),
    .SOURCE_OFF_CYCLES(OFF),
    .SOURCE_ON_CYCLES(ON)
  ) u_dut (
    .clock, .rst, .rx_valid, .rx_type, .tx_done, .tx_failed, .tx_req, .tx_type,
    .pm_swap_request, .pm_start_sink_ready, .pm_start_src_ready, .pm_reject_wait,
    .pm_reject_request, .pm_eval_ok, .pm_eval_not_ok, .pm_rp_asserted,
    .pm_rd_asserted, .pm_source_on, .pm_vbus_safe5v, .pm_contract,
    .frs_cc_detect_pin, .hard_reset_pin, .sink_off_req, .assert_rp_req,
    .assert_rd_req, .source_on_req, .frs_eval_query, .error_recovery,
    .src_hard_reset, .state
  );
  drs_port_model u_far (
    .clock, .tx_req, .tx_type, .lat, .fail, .tx_done, .tx_failed, .last
  );
  initial
  begin
    clock = 1'h0;
    forever #50 clock = ~clock;
  end
  task automatic summarize;
    if (mismatches == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  // bounded wait; a miss ends the run at once
  task automatic await(input logic [4:0] st, input int lim, output int waited);
    waited = 0;
    while (state !== st && waited < lim)
    begin
      @(negedge clock);
      waited++;
    end
    check("state", state, st);
    if (state !== st)
      summarize();
  endtask
  task automatic msg(input logic [3:0] t);
    rx_type = t;
    rx_valid = 1'h1;
    @(negedge clock);
    rx_valid = 1'h0;
  endtask
  task automatic home(input logic s);
    rst = 1'h1;
    {pm_swap_request, pm_start_sink_ready, pm_start_src_ready, pm_reject_wait,
     pm_reject_request, pm_eval_ok, pm_eval_not_ok, pm_rp_asserted, pm_rd_asserted,
     pm_source_on, pm_vbus_safe5v, pm_contract, frs_cc_detect_pin, hard_reset_pin,
     rx_valid, fail} = 16'h0000;
    rx_type = 4'h0;
    lat = 4'($urandom % 4);
    repeat (4) @(negedge clock);
    rst = 1'h0;
    check("reset state", state, `DRS_ST_DEFAULT);
    check("reset outs", {tx_req, error_recovery, src_hard_reset, sink_off_req}, 0);
    pm_start_src_ready = s;
    pm_start_sink_ready = !s;
    await(s ? `DRS_ST_SRC_READY : `DRS_ST_SNK_READY, 5, n);
    {pm_start_src_ready, pm_start_sink_ready} = 2'h0;
  endtask
  initial
  begin
    mismatches = 0;
    n_checks = 0;
    void'($urandom(91));
    // sink to source swap, ps_rdy delivered then lost
    for (k = 0; k < 2; k++)
    begin
      home(0);
      msg(`DRS_MSG_PR_SWAP);
      await(`DRS_ST_SNK_TO_OFF, 12, n);
      check("sent", last, `DRS_MSG_ACCEPT);
      @(negedge clock);
      check("sink off", sink_off_req, 1);
      msg(`DRS_MSG_PS_RDY);
      await(`DRS_ST_SNK_ASSERT_RP, 3, n);
      check("pull-up", assert_rp_req, 1);
      pm_rp_asserted = 1'h1;
      await(`DRS_ST_SNK_SOURCE_ON, 3, n);
      check("source on", source_on_req, 1);
      fail = k;
      pm_source_on = 1'h1;
      await(k ? `DRS_ST_ERROR_RECOVERY : `DRS_ST_SRC_STARTUP, 12, n);
      check("sent", last, `DRS_MSG_PS_RDY);
    end
    // partner never confirms its source is off
    home(0);
    msg(`DRS_MSG_PR_SWAP);
    await(`DRS_ST_SNK_TO_OFF, 12, n);
    await(`DRS_ST_ERROR_RECOVERY, OFF + 10, n);
    check("off wait", n >= OFF - 2, 1);
    // own swap request: reject, wait, silence, accept
    for (k = 0; k < 4; k++)
    begin
      home(0);
      pm_swap_request = 1'h1;
      await(`DRS_ST_SNK_SEND_SWAP, 4, n);
      pm_swap_request = 1'h0;
      repeat (3) @(negedge clock);
      check("sent", last, `DRS_MSG_PR_SWAP);
      if (k != 2)
        msg(k == 0 ? `DRS_MSG_REJECT : k == 1 ? `DRS_MSG_WAIT : `DRS_MSG_ACCEPT);
      await(k == 3 ? `DRS_ST_SNK_TO_OFF : `DRS_ST_SNK_READY, RESP + 10, n);
      if (k == 2)
        check("resp wait", n >= RESP - 5, 1);
    end
    // incoming swap refused now or deferred
    for (k = 0; k < 2; k++)
    begin
      home(0);
      pm_reject_request = 1'h1;
      pm_reject_wait = k;
      msg(`DRS_MSG_PR_SWAP);
      await(`DRS_ST_SNK_REJECT, 4, n);
      await(`DRS_ST_SNK_READY, 12, n);
      check("sent", last, k ? `DRS_MSG_WAIT : `DRS_MSG_REJECT);
    end
    // fast swap: ok, refused, accept lost, source timeout, ps_rdy lost, no cc signal
    for (k = 0; k < 6; k++)
    begin
      home(1);
      frs_cc_detect_pin = (k != 5);
      msg(`DRS_MSG_FR_SWAP);
      await(`DRS_ST_FRS_EVALUATE, 4, n);
      check("query", frs_eval_query, 1);
      fail = (k == 2);
      pm_eval_ok = (k != 1);
      pm_eval_not_ok = (k == 1);
      await(k == 1 || k == 2 || k == 5 ? `DRS_ST_SRC_HARD_RESET : `DRS_ST_FRS_TO_OFF,
            14, n);
      if (k == 1 || k == 2 || k == 5)
        check("hard rst", src_hard_reset, 1);
      else
      begin
        check("sent", last, `DRS_MSG_ACCEPT);
        fail = (k == 4);
        pm_vbus_safe5v = 1'h1;
        await(`DRS_ST_FRS_ASSERT_RD, 4, n);
        check("pull-down", assert_rd_req, 1);
        pm_rd_asserted = 1'h1;
        await(`DRS_ST_FRS_WAIT_SRC, 4, n);
        repeat (6) @(negedge clock);
        check("sent", last, `DRS_MSG_PS_RDY);
        if (k == 0)
          msg(`DRS_MSG_PS_RDY);
        await(k ? `DRS_ST_ERROR_RECOVERY : `DRS_ST_SNK_STARTUP, ON + 10, n);
        if (k == 3)
          check("on wait", n >= ON - 10, 1);
      end
    end
    // cc signal with contract, then hard reset mid-evaluation
    home(0);
    pm_contract = 1'h1;
    frs_cc_detect_pin = 1'h1;
    await(`DRS_ST_FRS_CC_SIGNAL, 6, n);
    msg(`DRS_MSG_FR_SWAP);
    await(`DRS_ST_FRS_EVALUATE, 4, n);
    hard_reset_pin = 1'h1;
    await(`DRS_ST_DEFAULT, 6, n);
    check("query", frs_eval_query, 0);
    summarize();
  end
endmodule // drs_swap_engine_tb_top
`default_nettype wire

// >>> drs_sync.v
// drs_sync.v: two-flop synchroniser for a bundle of levels
// assumes inputs are asynchronous levels held for several cycles
`timescale 1ns/1ps
`default_nettype none
module drs_sync #(
  parameter WIDTH = 8
) (
  input  wire             clock,
  input  wire             rst,
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] stage1;

  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      stage1   <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end
    else
    begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end
endmodule // drs_sync
`default_nettype wire

// >>> drs_timer.v
// drs_timer.v: one-shot down counter with start, stop and a one-cycle expiry pulse
// assumes start and stop come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module drs_timer #(
  parameter WIDTH = 24
) (
  input  wire             clock,
  input  wire             rst,
  input  wire             start,
  input  wire             stop,
  input  wire [WIDTH-1:0] load,
  output reg              expired
);
  reg [WIDTH-1:0] count;
  reg             running;

  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      count   <= {WIDTH{1'b0}};
      running <= 1'b0;
      expired <= 1'b0;
    end
    else
    begin
      expired <= 1'b0;
      // start wins over stop so a re-entry restarts cleanly
      if (start)
      begin
        count   <= load;
        running <= 1'b1;
      end
      else if (stop)
        running <= 1'b0;
      else if (running)
      begin
        if (count <= {{(WIDTH-1){1'b0}}, 1'b1})
        begin
          running <= 1'b0;
          expired <= 1'b1;
        end
        else
          count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule // drs_timer
`default_nettype wire
